// ===== rtl/irq_save_pkg.sv
// Purpose: shared constants and carriers for the interrupt save/restore unit
// Assumes: 32-bit addresses, big-endian bit numbering 32..63 maps to [31:0]
// Notes:   register indices are special-register numbers
`default_nettype none
package irq_save_pkg;
    // ------------------------------------------------------------------
    // register indices (byte address is not used: plain port)
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_RESUME      = 10'h01a;
    localparam logic [9:0] IDX_STATE_SAVE  = 10'h01b;
    localparam logic [9:0] IDX_CRIT_RESUME = 10'h03a;
    localparam logic [9:0] IDX_CRIT_STATE  = 10'h03b;
    localparam logic [9:0] IDX_FAULT_ADDR  = 10'h03d;
    localparam logic [9:0] IDX_VEC_BASE    = 10'h03f;
    localparam logic [9:0] IDX_OFFS_FIRST  = 10'h190;
    localparam int         NUM_OFFS        = 16;
    // ------------------------------------------------------------------
    // field layout (little-endian bit positions)
    // ------------------------------------------------------------------
    localparam int         VBASE_LSB       = 16;
    localparam logic [31:0] VBASE_MASK     = 32'hffff_0000;
    localparam int         VOFF_LSB        = 4;
    localparam logic [31:0] VOFF_MASK      = 32'h0000_fff0;
    localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
    // implemented machine-state bits kept on save; arbitrary default for this core
    localparam logic [31:0] MSTATE_VALID_MASK = 32'h0206_ff36;

    typedef enum logic [1:0] {
        RET_NONE  = 2'b00,
        RET_NONCR = 2'b01,
        RET_CRIT  = 2'b10,
        RET_DEBUG = 2'b11
    } ret_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SAVE  = 2'b01,
        ST_FETCH = 2'b10
    } vec_state_t;

    // interrupt entry request from the sequencer
    typedef struct packed {
        logic        valid;
        logic        critical;
        logic        data_fault;
        logic [3:0]  kind;
        logic [31:0] resume_pc;
        logic [31:0] fault_ea;
    } entry_req_t;

    // redirect towards instruction fetch
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } redirect_t;
endpackage
`default_nettype wire

// ===== rtl/vec_offset_mem.sv
// Purpose: small memory of per-type handler vector offsets
// Assumes: one write and one read port, read data registered
// Notes:   contents undefined until written, kept across reset
`default_nettype none
module vec_offset_mem #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock
    input  wire logic          core_clk_i,
    // write port
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [11:0]   wr_data_i,
    // read port
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [11:0]   rd_data_o
);
    logic [11:0] mem [DEPTH];

    // no reset on purpose: offsets survive core reset
    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule
`default_nettype wire

// ===== rtl/irq_save_restore.sv
// Purpose: interrupt save/restore registers and handler vectoring
// Assumes: sequencer issues entry or return at most once per cycle
// Notes:   save registers are not reset; only control state is
`default_nettype none
module irq_save_restore #(
    parameter int NOFFS = irq_save_pkg::NUM_OFFS
) (
    // clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     reset_i,
    // register port
    input  wire logic [9:0]               reg_addr_i,
    input  wire logic [31:0]              reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [31:0]              reg_rdata_o,
    // sequencer requests
    input  wire irq_save_pkg::entry_req_t entry_i,
    input  wire irq_save_pkg::ret_kind_t  ret_i,
    input  wire logic [31:0]              debug_state_i,
    input  wire logic [31:0]              mstate_i,
    // results
    output logic                          busy_o,
    output irq_save_pkg::redirect_t       redirect_o,
    output logic                          mstate_wr_o,
    output logic      [31:0]              mstate_wdata_o
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [31:0] res_pc_r,  res_pc_nxt;
    logic [31:0] sst_r,     sst_nxt;
    logic [31:0] crit_pc_r, crit_pc_nxt;
    logic [31:0] cst_r,   cst_nxt;
    logic [31:0] dfa_r,   dfa_nxt;
    logic [31:0] vbase_r, vbase_nxt;
    irq_save_pkg::vec_state_t state_r, state_nxt;
    logic [3:0]  kind_r,  kind_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    irq_save_pkg::redirect_t redir_r, redir_nxt;
    logic        mst_wr_r, mst_wr_nxt;
    logic [31:0] mst_wd_r, mst_wd_nxt;
    logic [11:0] offs_q;
    logic        offs_wr;
    logic [3:0]  offs_waddr;

    function automatic logic [31:0] state_clean(input logic [31:0] v);
        return v & irq_save_pkg::MSTATE_VALID_MASK;
    endfunction

    function automatic logic is_offs(input logic [9:0] a);
        return (a >= irq_save_pkg::IDX_OFFS_FIRST) &&
               (a < irq_save_pkg::IDX_OFFS_FIRST + 10'(NOFFS));
    endfunction

    assign offs_wr    = reg_wr_i && is_offs(reg_addr_i);
    assign offs_waddr = 4'(reg_addr_i - irq_save_pkg::IDX_OFFS_FIRST);

    vec_offset_mem #(.DEPTH(NOFFS), .AW(4)) u_offs (
        .core_clk_i (core_clk_i),
        .wr_en_i    (offs_wr),
        .wr_addr_i  (offs_waddr),
        .wr_data_i  (reg_wdata_i[15:4]),
        .rd_addr_i  (state_r == irq_save_pkg::ST_IDLE ? entry_i.kind : kind_r),
        .rd_data_o  (offs_q)
    );

    // ------------------------------------------------------------------
    // save register next values; hardware events win over software writes
    // ------------------------------------------------------------------
    always_comb begin
        res_pc_nxt  = res_pc_r;
        sst_nxt     = sst_r;
        crit_pc_nxt = crit_pc_r;
        cst_nxt     = cst_r;
        dfa_nxt     = dfa_r;
        vbase_nxt   = vbase_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                irq_save_pkg::IDX_RESUME:      res_pc_nxt  = reg_wdata_i;
                irq_save_pkg::IDX_STATE_SAVE:  sst_nxt = state_clean(reg_wdata_i);
                irq_save_pkg::IDX_CRIT_RESUME: crit_pc_nxt = reg_wdata_i;
                irq_save_pkg::IDX_CRIT_STATE:  cst_nxt = state_clean(reg_wdata_i);
                irq_save_pkg::IDX_FAULT_ADDR:  dfa_nxt     = reg_wdata_i;
                irq_save_pkg::IDX_VEC_BASE: begin
                    vbase_nxt = reg_wdata_i & irq_save_pkg::VBASE_MASK;
                end
                default: ;
            endcase
        end
        // entry accepted only when idle; returns never touch the other set
        if (entry_i.valid && state_r == irq_save_pkg::ST_IDLE) begin
            if (entry_i.critical) begin
                crit_pc_nxt = entry_i.resume_pc;
                cst_nxt     = state_clean(mstate_i);
            end else begin
                res_pc_nxt  = entry_i.resume_pc;
                sst_nxt     = state_clean(mstate_i);
            end
            if (entry_i.data_fault) begin
                dfa_nxt = entry_i.fault_ea;
            end
        end
    end

    // no reset: contents survive core reset, undefined at power-up
    always_ff @(posedge core_clk_i) begin
        res_pc_r  <= res_pc_nxt;
        sst_r     <= sst_nxt;
        crit_pc_r <= crit_pc_nxt;
        cst_r   <= cst_nxt;
        dfa_r   <= dfa_nxt;
        vbase_r <= vbase_nxt;
    end

    // ------------------------------------------------------------------
    // vectoring sequence: save, then fetch from base joined with offset
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        kind_nxt   = kind_r;
        redir_nxt  = '0;
        mst_wr_nxt = 1'b0;
        mst_wd_nxt = mst_wd_r;
        case (state_r)
            irq_save_pkg::ST_IDLE: begin
                if (entry_i.valid) begin
                    kind_nxt  = entry_i.kind;
                    state_nxt = irq_save_pkg::ST_SAVE;
                end else begin
                    // return: restore the matching set only; redirect on non-critical and critical returns, not debug
                    case (ret_i)
                        irq_save_pkg::RET_NONCR: begin
                            redir_nxt  = '{valid: 1'b1, addr: res_pc_r};
                            mst_wr_nxt = 1'b1;
                            mst_wd_nxt = sst_r;
                        end
                        irq_save_pkg::RET_CRIT: begin
                            redir_nxt  = '{valid: 1'b1, addr: crit_pc_r};
                            mst_wr_nxt = 1'b1;
                            mst_wd_nxt = cst_r;
                        end
                        irq_save_pkg::RET_DEBUG: begin
                            mst_wr_nxt = 1'b1;
                            mst_wd_nxt = debug_state_i;
                        end
                        default: ;
                    endcase
                end
            end
            irq_save_pkg::ST_SAVE: begin
                // saves landed last edge; offset read data valid now
                redir_nxt.valid = 1'b1;
                redir_nxt.addr  = (vbase_r & irq_save_pkg::VBASE_MASK) |
                                  {16'h0000, offs_q, 4'h0};
                state_nxt = irq_save_pkg::ST_FETCH;
            end
            irq_save_pkg::ST_FETCH: begin
                state_nxt = irq_save_pkg::ST_IDLE;
            end
            default: state_nxt = irq_save_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_r  <= irq_save_pkg::ST_IDLE;
            kind_r   <= 4'h0;
            redir_r  <= '0;
            mst_wr_r <= 1'b0;
            mst_wd_r <= irq_save_pkg::RESET_VALUE;
        end else begin
            state_r  <= state_nxt;
            kind_r   <= kind_nxt;
            redir_r  <= redir_nxt;
            mst_wr_r <= mst_wr_nxt;
            mst_wd_r <= mst_wd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // register read, data one cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = irq_save_pkg::RESET_VALUE;
        if (reg_rd_i) begin
            case (reg_addr_i)
                irq_save_pkg::IDX_RESUME:      rdata_nxt = res_pc_r;
                irq_save_pkg::IDX_STATE_SAVE:  rdata_nxt = sst_r;
                irq_save_pkg::IDX_CRIT_RESUME: rdata_nxt = crit_pc_r;
                irq_save_pkg::IDX_CRIT_STATE:  rdata_nxt = cst_r;
                irq_save_pkg::IDX_FAULT_ADDR:  rdata_nxt = dfa_r;
                irq_save_pkg::IDX_VEC_BASE:    rdata_nxt = vbase_r;
                default:                       rdata_nxt = irq_save_pkg::RESET_VALUE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_r <= irq_save_pkg::RESET_VALUE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign redirect_o  = redir_r;
    assign mstate_wr_o    = mst_wr_r;
    assign mstate_wdata_o = mst_wd_r;
    assign busy_o      = (state_r != irq_save_pkg::ST_IDLE); // handshake, combinational

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence noncrit_entry_s;
        entry_i.valid && !entry_i.critical && state_r == irq_save_pkg::ST_IDLE;
    endsequence
    sequence crit_entry_s;
        entry_i.valid && entry_i.critical && state_r == irq_save_pkg::ST_IDLE;
    endsequence

    resume_save_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        noncrit_entry_s |=> res_pc_r == $past(entry_i.resume_pc))
        else $error("resume address not saved");
    state_save_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        noncrit_entry_s |=> sst_r == ($past(mstate_i) & irq_save_pkg::MSTATE_VALID_MASK))
        else $error("machine state not saved");
    crit_save_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        crit_entry_s |=> crit_pc_r == $past(entry_i.resume_pc) && res_pc_r == $past(res_pc_r))
        else $error("critical resume address wrong");
    ret_redirect_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state_r == irq_save_pkg::ST_IDLE && !entry_i.valid &&
         ret_i == irq_save_pkg::RET_NONCR) |=> redirect_o.valid &&
         redirect_o.addr == $past(res_pc_r) && mstate_wdata_o == $past(sst_r))
        else $error("return redirect wrong");
    crit_ret_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state_r == irq_save_pkg::ST_IDLE && !entry_i.valid &&
         ret_i == irq_save_pkg::RET_CRIT) |=> redirect_o.addr == $past(crit_pc_r) &&
         mstate_wr_o && mstate_wdata_o == $past(cst_r))
        else $error("critical return wrong");
    keep_saves_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ret_i == irq_save_pkg::RET_DEBUG && !entry_i.valid && !reg_wr_i) |=>
        $stable(res_pc_r) && $stable(crit_pc_r) && $stable(sst_r) && $stable(cst_r))
        else $error("debug return touched saves");
    fault_addr_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (noncrit_entry_s and entry_i.data_fault) |=> dfa_r == $past(entry_i.fault_ea))
        else $error("fault address not captured");
    vector_order_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        noncrit_entry_s |-> !redirect_o.valid ##1 !redirect_o.valid ##1
        (redirect_o.valid && redirect_o.addr[31:16] == vbase_r[31:16] &&
         redirect_o.addr[3:0] == 4'h0))
        else $error("handler fetch out of order");
    // checked after each base write: the base is undefined until software sets it
    base_align_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_wr_i && reg_addr_i == irq_save_pkg::IDX_VEC_BASE) |=> vbase_r[15:0] == 16'h0000)
        else $error("vector base low bits set");
endmodule
`default_nettype wire

// ===== verification/seq_model.sv
// Purpose: behavioural model of the pipeline side that owns machine state
// Assumes: state loads from the unit arrive as one-cycle pulses
// Notes:   the bench may preload state to set up an interrupt entry
`default_nettype none
module seq_model (
    // clock
    input  wire logic        core_clk_i,
    // bench preload
    input  wire logic        load_i,
    input  wire logic [31:0] load_val_i,
    // unit side
    input  wire logic        mstate_wr_i,
    input  wire logic [31:0] mstate_wdata_i,
    output logic      [31:0] mstate_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] mstate_r;

    // a restore from the unit wins; the bench never preloads during a return
    always_ff @(posedge core_clk_i) begin
        if (mstate_wr_i) begin
            mstate_r <= mstate_wdata_i;
        end else if (load_i) begin
            mstate_r <= load_val_i;
        end
    end

    assign mstate_o = mstate_r;
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the interrupt save/restore unit
// Assumes: fixed return latency as handed over; entry redirect awaited for up to 8 cycles
// Notes:   return state compares are masked, returns may touch reserved bits
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] BASE = 32'h5a3c_0000;
    localparam logic [31:0] MASK = irq_save_pkg::MSTATE_VALID_MASK;

    logic core_clk_i, reset_i, reg_wr_i, reg_rd_i, busy_o, mstate_wr_o, load_r;
    logic [9:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, mstate_i, mstate_wdata_o, dbg_state;
    logic [31:0] load_val_r, rd_v;
    irq_save_pkg::entry_req_t entry_i;
    irq_save_pkg::ret_kind_t  ret_i;
    irq_save_pkg::redirect_t  redirect_o;
    int err_total, n_compared;

    irq_save_restore dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .entry_i(entry_i), .ret_i(ret_i),
        .debug_state_i(dbg_state), .mstate_i(mstate_i), .busy_o(busy_o),
        .redirect_o(redirect_o), .mstate_wr_o(mstate_wr_o),
        .mstate_wdata_o(mstate_wdata_o));

    seq_model seq_u (.core_clk_i(core_clk_i), .load_i(load_r), .load_val_i(load_val_r),
        .mstate_wr_i(mstate_wr_o), .mstate_wdata_i(mstate_wdata_o), .mstate_o(mstate_i));

    // --------------------------------------------------------------
    // shared helpers
    // --------------------------------------------------------------
    // 20 MHz core clock
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [9:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic set_msr(input logic [31:0] v);
        @(posedge core_clk_i);
        load_r <= 1'b1;
        load_val_r <= v;
        @(posedge core_clk_i);
        load_r <= 1'b0;
    endtask

    function automatic logic [31:0] off_val(input logic [3:0] k);
        return 32'h0000_1000 | ({28'h000_0000, k} << 4);
    endfunction

    task automatic take_entry(input logic crit, input logic df, input logic [3:0] k,
                              input logic [31:0] pc, input logic [31:0] ea);
        int n;
        logic [31:0] exp_a;
        @(posedge core_clk_i);
        entry_i <= '{1'b1, crit, df, k, pc, ea};
        @(posedge core_clk_i);
        entry_i.valid <= 1'b0;
        #1 check({31'h0, busy_o}, 32'h0000_0001);
        check({31'h0, redirect_o.valid}, 32'h0000_0000);
        for (n = 0; n < 8 && redirect_o.valid !== 1'b1; n++) begin
            @(posedge core_clk_i);
            #1;
        end
        if (n == 8) begin
            err_total++;
            tally_and_finish();
        end
        exp_a = (BASE & irq_save_pkg::VBASE_MASK) | (off_val(k) & irq_save_pkg::VOFF_MASK);
        check(redirect_o.addr, exp_a);
    endtask

    task automatic do_return(input irq_save_pkg::ret_kind_t k, input logic [31:0] pc,
                             input logic [31:0] st, input logic redir);
        @(posedge core_clk_i);
        ret_i <= k;
        @(posedge core_clk_i);
        ret_i <= irq_save_pkg::RET_NONE;
        #1 check({31'h0, mstate_wr_o}, 32'h0000_0001);
        check(mstate_wdata_o & MASK, st & MASK);
        check({31'h0, redirect_o.valid}, {31'h0, redir});
        if (redir) check(redirect_o.addr, pc);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_regs();
        reg_write(irq_save_pkg::IDX_VEC_BASE, BASE);
        for (int k = 0; k < 16; k++) begin
            reg_write(irq_save_pkg::IDX_OFFS_FIRST + 10'(k), off_val(4'(k)));
        end
        reg_read(irq_save_pkg::IDX_VEC_BASE, rd_v);
        check(rd_v, BASE);
        reg_read(10'h3ff, rd_v);
        check(rd_v, 32'h0000_0000);
    endtask

    // data faults reuse the non-critical save path, so the last one wins
    task automatic t_noncrit();
        logic [3:0] kinds [3];
        kinds = '{4'h2, 4'h5, 4'hd};
        set_msr(32'hffff_ffff);
        take_entry(1'b0, 1'b0, 4'h4, 32'h0000_1000, 32'h0000_0000);
        reg_read(irq_save_pkg::IDX_RESUME, rd_v);
        check(rd_v, 32'h0000_1000);
        reg_read(irq_save_pkg::IDX_STATE_SAVE, rd_v);
        check(rd_v, MASK);
        foreach (kinds[i]) begin
            take_entry(1'b0, 1'b1, kinds[i], 32'h0000_2000 + 32'(i), 32'hdead_0000 + 32'(i));
            reg_read(irq_save_pkg::IDX_FAULT_ADDR, rd_v);
            check(rd_v, 32'hdead_0000 + 32'(i));
        end
    endtask

    task automatic t_crit_returns();
        set_msr(32'h0200_0030);
        take_entry(1'b1, 1'b0, 4'h0, 32'h0000_3000, 32'h0000_0000);
        reg_read(irq_save_pkg::IDX_CRIT_RESUME, rd_v);
        check(rd_v, 32'h0000_3000);
        reg_read(irq_save_pkg::IDX_CRIT_STATE, rd_v);
        check(rd_v, 32'h0200_0030 & MASK);
        do_return(irq_save_pkg::RET_DEBUG, 32'h0, dbg_state, 1'b0);
        reg_read(irq_save_pkg::IDX_RESUME, rd_v);
        check(rd_v, 32'h0000_2002);
        reg_read(irq_save_pkg::IDX_CRIT_RESUME, rd_v);
        check(rd_v, 32'h0000_3000);
        do_return(irq_save_pkg::RET_NONCR, 32'h0000_2002, MASK, 1'b1);
        do_return(irq_save_pkg::RET_CRIT, 32'h0000_3000, 32'h0200_0030, 1'b1);
        reg_read(irq_save_pkg::IDX_STATE_SAVE, rd_v);
        check(rd_v & MASK, MASK);
        do_return(irq_save_pkg::RET_CRIT, 32'h0000_3000, 32'h0200_0030, 1'b1);
    endtask

    // a core reset in mid-run must leave saved addresses and the base alone
    task automatic t_reset_keep();
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        @(posedge core_clk_i);
        reset_i <= 1'b0;
        #1 check({31'h0, redirect_o.valid}, 32'h0000_0000);
        reg_read(irq_save_pkg::IDX_RESUME, rd_v);
        check(rd_v, 32'h0000_2002);
        reg_read(irq_save_pkg::IDX_CRIT_RESUME, rd_v);
        check(rd_v, 32'h0000_3000);
        reg_read(irq_save_pkg::IDX_VEC_BASE, rd_v);
        check(rd_v, BASE);
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        err_total = 0;
        n_compared = 0;
        reset_i = 1'b1;
        {reg_wr_i, reg_rd_i, load_r} = 3'b000;
        reg_addr_i = 10'h000;
        reg_wdata_i = 32'h0000_0000;
        load_val_r = 32'h0000_0000;
        dbg_state = 32'h0006_0030;
        entry_i = '0;
        ret_i = irq_save_pkg::RET_NONE;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_noncrit();
        t_crit_returns();
        t_reset_keep();
        tally_and_finish();
    end
endmodule
`default_nettype wire
